/* File: hw/map_unit_regs.vh */
// Purpose: Shared constants of the engine LED mapping unit.
// Assumes: Included by its bare name from every design file.
// Notes:   Instruction fields, row layout, readback offsets, states and timing.
`ifndef MAP_UNIT_REGS_VH
`define MAP_UNIT_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// Sizes.
`define NUM_ENG 3
`define NUM_LED 9
`define ADDR_W 7
`define WORD_W 16
`define ROW_W 10
`define PWM_W 12
`define PWM_HOST_W 8
`define PWM_FRAC_W 4
`define ENG_IDX_W 2
`define LED_IDX_W 4

////////////////////////////////////////////////////////////////////////////////
// Instruction word fields.
`define GRP_HI 15
`define GRP_LO 10
`define GRP_CODE 6'h27
`define SUB_HI 9
`define SUB_LO 7
`define SUB_MAP_START 3'h0
`define SUB_LOAD_END 3'h1
`define SUB_SEL 3'h2
`define SUB_STEP 3'h3
`define SUB_LOAD_START 3'h4
`define SUB_LOAD_ADDR 3'h6
`define SUB_MAP_ADDR 3'h7
`define BIT_PREV 6
`define BIT_PTR_ONLY 0
`define ADDR_HI 6
`define ADDR_LO 0

////////////////////////////////////////////////////////////////////////////////
// Mapping row layout.
`define ROW_LED_HI 8
`define ROW_FADER 9
`define ROW_RESET 10'h000

////////////////////////////////////////////////////////////////////////////////
// Pointer operations.
`define PTR_NONE 3'h0
`define PTR_SET_START 3'h1
`define PTR_SET_END 3'h2
`define PTR_SET 3'h3
`define PTR_NEXT 3'h4
`define PTR_PREV 3'h5
`define PTR_RESET 7'h00

////////////////////////////////////////////////////////////////////////////////
// Host readback window, owner code for a free LED, sequencer states.
`define MAP_REG_BASE 8'h70
`define MAP_REG_LAST 8'h75
`define OWNER_NONE 2'h3
`define ST_IDLE 2'h0
`define ST_READ 2'h1
`define ST_LOAD 2'h2

////////////////////////////////////////////////////////////////////////////////
// Timing.
`define MCLK_HZ 250000000
`define ENGINE_HZ 32768
`define TICK_CNT_W 13
`define TICK_CNT_RESET 13'h0000

`endif

/* File: hw/engine_tick_gen.v */
// Purpose: Divides mclk down to the one-cycle engine clock enable.
// Assumes: DIV_COUNT is at least one and fits the counter.
// Notes:   The tick is high on the last cycle of every period.
`timescale 1ns/10ps
`include "map_unit_regs.vh"

module engine_tick_gen #(
    parameter DIV_COUNT = `MCLK_HZ / `ENGINE_HZ
) (
    // Clock and reset
    input wire mclk,
    input wire rst_b,
    // Enable pulse
    output wire tick
);

localparam integer LAST_INT = DIV_COUNT - 1;
localparam [`TICK_CNT_W-1:0] LAST = LAST_INT[`TICK_CNT_W-1:0];

reg [`TICK_CNT_W-1:0] count;

assign tick = (count == LAST);

always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
        count <= `TICK_CNT_RESET;
    end else if (tick) begin
        count <= `TICK_CNT_RESET;
    end else begin
        count <= count + 1'b1;
    end
end

endmodule

/* File: hw/engine_row_pointer.v */
// Purpose: Table start, end and row pointer of one engine.
// Assumes: Operations arrive as one-cycle enables from the decoder.
// Notes:   next_ptr shows the pointer as the pending operation will leave it.
`timescale 1ns/10ps
`include "map_unit_regs.vh"

module engine_row_pointer (
    // Clock and reset
    input wire mclk,
    input wire rst_b,
    // Operation
    input wire op_en,
    input wire [2:0] op,
    input wire [`ADDR_W-1:0] op_addr,
    // State
    output reg [`ADDR_W-1:0] row_ptr,
    output reg [`ADDR_W-1:0] next_ptr
);

reg [`ADDR_W-1:0] table_start;
reg [`ADDR_W-1:0] table_end;

always @* begin
    next_ptr = row_ptr;
    if (op_en) begin
        case (op)
            `PTR_SET_START: next_ptr = op_addr;
            `PTR_SET: next_ptr = op_addr;
            `PTR_NEXT: next_ptr = (row_ptr == table_end) ? table_start : row_ptr + 1'b1;
            `PTR_PREV: next_ptr = (row_ptr == table_start) ? table_end : row_ptr - 1'b1;
            default: next_ptr = row_ptr;
        endcase
    end
end

always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
        table_start <= `PTR_RESET;
        table_end <= `PTR_RESET;
        row_ptr <= `PTR_RESET;
    end else begin
        row_ptr <= next_ptr;
        if (op_en && op == `PTR_SET_START) begin
            table_start <= op_addr;
        end
        if (op_en && op == `PTR_SET_END) begin
            table_end <= op_addr;
        end
    end
end

endmodule

/* File: hw/engine_led_mapping_unit.v */
// Purpose: Decodes engine LED mapping instructions and routes engine PWM to nine drivers.
// Assumes: Table rows return from SRAM one cycle after sram_rd; engine index 3 is unused.
// Notes:   Instructions are taken only on the engine clock enable.
// Operation
// - Table start, end and row pointers are seven bits, lower half of SRAM.
// - Each engine row may connect any subset of the nine drivers.
// - Shared LED goes to engine 1, then engine 2, then engine 3.
// - Activating instructions load the selected row as the live connection.
// - Pointer-only instructions move or define the pointer, leaving connections unchanged.
// - Rows and fader bits are host readable at 70h-75h, engine written only.
// - An engine-owned LED takes engine PWM and ignores host PWM writes.
// - An LED no longer mapped returns to its host PWM register.
// - Mapping changes alone never update drivers; only an engine PWM update strobe or a host PWM write does.
// - A released LED keeps the engine's last value in its PWM register.
// - PWM is twelve bits; host sees and writes only the upper eight.
// - Row bits 0 to 8 connect drivers 0 to 8, one per bit.
// - Row bit 9 enables the executing engine's own master fader.
// - Mapping opcodes use bits 15:10, a sub-code in 9:7 and address 6:0.
// - A forward step at the table end wraps to the table start.
// - A backward step at the table start wraps to the table end.
// - Direct select 1 to 9 connects one driver; other values connect none.
`timescale 1ns/10ps
`include "map_unit_regs.vh"

module engine_led_mapping_unit #(
    parameter TICK_DIV = `MCLK_HZ / `ENGINE_HZ
) (
    // Clock and reset
    input wire mclk,
    input wire rst_b,
    // Engine timebase
    output wire engine_tick,
    // Instruction issue
    input wire instr_valid,
    input wire [`ENG_IDX_W-1:0] instr_engine,
    input wire [`WORD_W-1:0] instr_word,
    output wire instr_ready,
    // Mapping table fetch
    output wire sram_rd,
    output reg [`ADDR_W-1:0] sram_addr,
    input wire [`WORD_W-1:0] sram_rdata,
    // Engine PWM values
    input wire [`PWM_W-1:0] eng_pwm_1,
    input wire [`PWM_W-1:0] eng_pwm_2,
    input wire [`PWM_W-1:0] eng_pwm_3,
    input wire [`NUM_ENG-1:0] eng_pwm_upd,
    // Host PWM writes
    input wire host_pwm_wr,
    input wire [`LED_IDX_W-1:0] host_pwm_sel,
    input wire [`PWM_HOST_W-1:0] host_pwm_wdata,
    // Host mapping readback
    input wire [7:0] map_read_addr,
    output reg [7:0] map_read_data,
    // Driver side
    output wire [`NUM_LED*`PWM_W-1:0] driver_output_n,
    output wire [`NUM_LED*`PWM_HOST_W-1:0] pwm_reg,
    output wire [`NUM_LED-1:0] engine_owned,
    output wire [`NUM_ENG-1:0] fader_en,
    output wire [`NUM_ENG*`ADDR_W-1:0] row_ptr
);

////////////////////////////////////////////////////////////////////////////////
// Functions.

// Picks the highest-priority engine that claims an LED.
function [`ENG_IDX_W-1:0] led_owner;
    input [`NUM_ENG-1:0] claims;
    begin
        if (claims[0]) begin
            led_owner = 2'h0;
        end else if (claims[1]) begin
            led_owner = 2'h1;
        end else if (claims[2]) begin
            led_owner = 2'h2;
        end else begin
            led_owner = `OWNER_NONE;
        end
    end
endfunction

// Direct driver select: values 1 to 9 give one driver, anything else none.
function [`NUM_LED-1:0] sel_onehot;
    input [`ADDR_W-1:0] value;
    integer k;
    begin
        sel_onehot = {`NUM_LED{1'b0}};
        for (k = 0; k < `NUM_LED; k = k + 1) begin
            if (value == k + 1) begin
                sel_onehot[k] = 1'b1;
            end
        end
    end
endfunction

// Engine PWM value by engine index.
function [`PWM_W-1:0] pick_pwm;
    input [`ENG_IDX_W-1:0] idx;
    input [`PWM_W-1:0] p1;
    input [`PWM_W-1:0] p2;
    input [`PWM_W-1:0] p3;
    begin
        case (idx)
            2'h0: pick_pwm = p1;
            2'h1: pick_pwm = p2;
            default: pick_pwm = p3;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Engine clock enable.

engine_tick_gen #(
    .DIV_COUNT(TICK_DIV)
) u_tick (
    .mclk(mclk),
    .rst_b(rst_b),
    .tick(engine_tick)
);

////////////////////////////////////////////////////////////////////////////////
// Instruction decode.

reg [1:0] state;
reg [`ENG_IDX_W-1:0] fetch_eng;
reg [`ROW_W-1:0] active_row [0:`NUM_ENG-1];
reg [2:0] next_ptr_op;
reg next_fetch;
reg next_sel;

wire accept = instr_valid && instr_ready;
wire eng_ok = (instr_engine != `OWNER_NONE);
wire grp_ok = (instr_word[`GRP_HI:`GRP_LO] == `GRP_CODE);
wire [2:0] sub = instr_word[`SUB_HI:`SUB_LO];
wire [`ADDR_W-1:0] op_addr = instr_word[`ADDR_HI:`ADDR_LO];
wire [`NUM_ENG*`ADDR_W-1:0] next_ptr_flat;
reg [`ADDR_W-1:0] fetch_ptr;

assign instr_ready = (state == `ST_IDLE) && engine_tick;
assign sram_rd = (state == `ST_READ);

always @* begin
    next_ptr_op = `PTR_NONE;
    next_fetch = 1'b0;
    next_sel = 1'b0;
    if (accept && grp_ok && eng_ok) begin
        case (sub)
            `SUB_LOAD_START: begin
                next_ptr_op = `PTR_SET_START;
            end
            `SUB_MAP_START: begin
                next_ptr_op = `PTR_SET_START;
                next_fetch = 1'b1;
            end
            `SUB_LOAD_END: begin
                next_ptr_op = `PTR_SET_END;
            end
            `SUB_LOAD_ADDR: begin
                next_ptr_op = `PTR_SET;
            end
            `SUB_MAP_ADDR: begin
                next_ptr_op = `PTR_SET;
                next_fetch = 1'b1;
            end
            `SUB_STEP: begin
                next_ptr_op = instr_word[`BIT_PREV] ? `PTR_PREV : `PTR_NEXT;
                next_fetch = !instr_word[`BIT_PTR_ONLY];
            end
            `SUB_SEL: begin
                next_sel = 1'b1;
            end
            default: begin
                next_ptr_op = `PTR_NONE;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Per-engine table pointers.

genvar e;
generate
    for (e = 0; e < `NUM_ENG; e = e + 1) begin : g_eng
        localparam [`ENG_IDX_W-1:0] ENG_IDX = e;
        engine_row_pointer u_ptr (
            .mclk(mclk),
            .rst_b(rst_b),
            .op_en(next_ptr_op != `PTR_NONE && instr_engine == ENG_IDX),
            .op(next_ptr_op),
            .op_addr(op_addr),
            .row_ptr(row_ptr[e*`ADDR_W +: `ADDR_W]),
            .next_ptr(next_ptr_flat[e*`ADDR_W +: `ADDR_W])
        );
        assign fader_en[e] = active_row[e][`ROW_FADER];
    end
endgenerate

always @* begin
    case (instr_engine)
        2'h0: fetch_ptr = next_ptr_flat[0 +: `ADDR_W];
        2'h1: fetch_ptr = next_ptr_flat[`ADDR_W +: `ADDR_W];
        default: fetch_ptr = next_ptr_flat[2*`ADDR_W +: `ADDR_W];
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// Row fetch and live mapping.

integer r;
always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
        state <= `ST_IDLE;
        fetch_eng <= 2'h0;
        sram_addr <= `PTR_RESET;
        for (r = 0; r < `NUM_ENG; r = r + 1) begin
            active_row[r] <= `ROW_RESET;
        end
    end else begin
        case (state)
            `ST_IDLE: begin
                if (next_fetch) begin
                    state <= `ST_READ;
                    fetch_eng <= instr_engine;
                    sram_addr <= fetch_ptr;
                end
                if (next_sel) begin
                    active_row[instr_engine] <= {1'b0, sel_onehot(op_addr)};
                end
            end
            `ST_READ: begin
                state <= `ST_LOAD;
            end
            `ST_LOAD: begin
                state <= `ST_IDLE;
                active_row[fetch_eng] <= sram_rdata[`ROW_W-1:0];
            end
            default: begin
                state <= `ST_IDLE;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Per-LED ownership and PWM level.

genvar i;
generate
    for (i = 0; i < `NUM_LED; i = i + 1) begin : g_led
        localparam [`LED_IDX_W-1:0] LED_IDX = i;
        wire [`NUM_ENG-1:0] claims = {active_row[2][i], active_row[1][i], active_row[0][i]};
        wire [`ENG_IDX_W-1:0] owner = led_owner(claims);
        reg [`PWM_W-1:0] level;

        // Level doubles as the host PWM register, so a release keeps the last engine value.
        always @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
                level <= {`PWM_W{1'b0}};
            end else if (owner != `OWNER_NONE) begin
                if (eng_pwm_upd[owner]) begin
                    level <= pick_pwm(owner, eng_pwm_1, eng_pwm_2, eng_pwm_3);
                end
            end else if (host_pwm_wr && host_pwm_sel == LED_IDX) begin
                level <= {host_pwm_wdata, {`PWM_FRAC_W{1'b0}}};
            end
        end

        assign engine_owned[i] = (owner != `OWNER_NONE);
        assign driver_output_n[i*`PWM_W +: `PWM_W] = level;
        assign pwm_reg[i*`PWM_HOST_W +: `PWM_HOST_W] = level[`PWM_W-1:`PWM_FRAC_W];
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Host readback of live rows; even offset high byte, odd offset low byte.

wire [7:0] rd_off = map_read_addr - `MAP_REG_BASE;
wire rd_hit = (map_read_addr >= `MAP_REG_BASE) && (map_read_addr <= `MAP_REG_LAST);
wire [`ROW_W-1:0] rd_row = active_row[rd_off[2:1]];

always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
        map_read_data <= 8'h00;
    end else if (!rd_hit) begin
        map_read_data <= 8'h00;
    end else if (rd_off[0]) begin
        map_read_data <= rd_row[7:0];
    end else begin
        map_read_data <= {6'h00, rd_row[`ROW_W-1:8]};
    end
end

endmodule

/* File: bench/row_store.sv */
// Purpose: Program memory model that returns mapping table rows.
// Assumes: Rows are loaded by the bench before reset is released.
// Notes:   Outside the answer cycle the data lines toggle, so a stale row is never seen.
`timescale 1ns/10ps

module row_store (
    // Clock
    input wire mclk,
    // Read port
    input wire sram_rd,
    input wire [6:0] sram_addr,
    output reg [15:0] sram_rdata
);
    reg [15:0] mem [0:127];
    initial sram_rdata = 16'h5A5A;
    always @(posedge mclk) begin
        if (sram_rd) begin
            sram_rdata <= mem[sram_addr];
        end else begin
            sram_rdata <= ~sram_rdata;
        end
    end
endmodule

/* File: bench/map_unit_checker.sv */
// Purpose: Port level checks of the mapping unit.
// Assumes: Bound to every engine_led_mapping_unit.
// Notes:   Instruction checks watch engine 1, which always wins.
`timescale 1ns/10ps

module map_unit_checker (
    // Clock and reset
    input wire mclk,
    input wire rst_b,
    // Instruction side
    input wire instr_valid,
    input wire [1:0] instr_engine,
    input wire [15:0] instr_word,
    input wire instr_ready,
    input wire sram_rd,
    input wire [6:0] sram_addr,
    // PWM and readback
    input wire [2:0] eng_pwm_upd,
    input wire host_pwm_wr,
    input wire [3:0] host_pwm_sel,
    input wire [7:0] host_pwm_wdata,
    input wire [7:0] map_read_addr,
    input wire [7:0] map_read_data,
    input wire [107:0] driver_output_n,
    input wire [71:0] pwm_reg,
    input wire [8:0] engine_owned,
    input wire [2:0] fader_en,
    input wire [20:0] row_ptr
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    wire go = instr_valid && instr_ready;
    wire take = go && instr_word[15:10] == 6'h27 && instr_engine == 2'h0;
    wire [2:0] sub = instr_word[9:7];
    wire [6:0] arg = instr_word[6:0];
    ////////////////////////////////////////
    property p_map_fetch;
        take && sub == 3'h7 |=> sram_rd && sram_addr == $past(arg) && row_ptr[6:0] == $past(arg);
    endproperty
    a_map_fetch: assert property (p_map_fetch) else $error("row fetch wrong");
    property p_load_addr;
        take && sub == 3'h6 |=> (!sram_rd)[*2] ##0 row_ptr[6:0] == $past(arg, 2);
    endproperty
    a_load_addr: assert property (p_load_addr) else $error("pointer load wrong");
    property p_sel_one;
        take && sub == 3'h2 && arg == 7'h05 |=> ##1 engine_owned[4] && !fader_en[0];
    endproperty
    a_sel_one: assert property (p_sel_one) else $error("direct select wrong");
    property p_owned_cause;
        $changed(engine_owned) |-> $past(sram_rd, 2) || $past(sram_rd, 3) || $past(go) || $past(go, 2);
    endproperty
    a_owned_cause: assert property (p_owned_cause) else $error("mapping moved alone");
    property p_drv_cause;
        $changed(driver_output_n) |-> $past(host_pwm_wr) || (|$past(eng_pwm_upd));
    endproperty
    a_drv_cause: assert property (p_drv_cause) else $error("level moved alone");
    property p_host_wr;
        host_pwm_wr && host_pwm_sel < 4'h9 && !engine_owned[host_pwm_sel] |=>
            driver_output_n[$past(host_pwm_sel)*12 +: 12] == {$past(host_pwm_wdata), 4'h0};
    endproperty
    a_host_wr: assert property (p_host_wr) else $error("host write lost");
    property p_host_ign;
        host_pwm_wr && host_pwm_sel < 4'h9 && engine_owned[host_pwm_sel] && eng_pwm_upd == 3'h0 |=>
            $stable(pwm_reg);
    endproperty
    a_host_ign: assert property (p_host_ign) else $error("owned level taken from host");
    property p_read_out;
        map_read_addr < 8'h70 || map_read_addr > 8'h75 |=> map_read_data == 8'h00;
    endproperty
    a_read_out: assert property (p_read_out) else $error("readback outside window");
endmodule

bind engine_led_mapping_unit map_unit_checker i_map_unit_checker (.*);

/* File: bench/testbench.sv */
// Purpose: Random and corner checks of the mapping unit.
// Assumes: Row store answers one cycle after each read.
// Notes:   Inputs change at the falling edge only.
`timescale 1ns/10ps

module testbench;
    localparam TICK_DIV = 8;
    reg mclk, rst_b, instr_valid, host_pwm_wr;
    reg [1:0] instr_engine;
    reg [15:0] instr_word, r;
    reg [11:0] eng_pwm_1, eng_pwm_2, eng_pwm_3;
    reg [2:0] eng_pwm_upd;
    reg [3:0] host_pwm_sel;
    reg [7:0] host_pwm_wdata, map_read_addr;
    wire engine_tick, instr_ready, sram_rd;
    wire [6:0] sram_addr;
    wire [15:0] sram_rdata;
    wire [7:0] map_read_data;
    wire [107:0] driver_output_n;
    wire [71:0] pwm_reg;
    wire [8:0] engine_owned;
    wire [2:0] fader_en;
    wire [20:0] row_ptr;
    integer errors = 0, n_tests = 0, cyc = 0, i, k;
    integer gap = 0, seen = 0;
    reg [6:0] st [0:2], en [0:2], pt [0:2];
    reg [9:0] rw [0:2];
    reg [107:0] lvl;
    engine_led_mapping_unit #(.TICK_DIV(TICK_DIV)) i_engine_led_mapping_unit (.*);
    row_store i_row_store (.*);
    ////////////////////////////////////////
    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function [71:0] hi8(input [107:0] v);
        integer n;
        for (n = 0; n < 9; n = n + 1) hi8[n*8 +: 8] = v[n*12+4 +: 8];
    endfunction
    function [7:0] rb(input [7:0] a);
        reg [9:0] w;
        rb = 8'h00;
        if (a >= 8'h70 && a <= 8'h75) begin
            w = rw[(a - 8'h70) >> 1];
            rb = a[0] ? w[7:0] : {6'h00, w[9:8]};
        end
    endfunction
    task chk_map(input [20:0] got, input [20:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task chk_pwm(input [107:0] got, input [107:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task test_done;
        if (errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task model_op(input [1:0] e, input [15:0] w);
        reg [6:0] a;
        a = w[6:0];
        if (w[15:10] == 6'h27 && e != 2'h3) begin
            case (w[9:7])
                3'h0, 3'h4: begin
                    st[e] = a;
                    pt[e] = a;
                end
                3'h1: en[e] = a;
                3'h2: rw[e] = (a >= 7'h01 && a <= 7'h09) ? 10'h001 << (a - 7'h01) : 10'h000;
                3'h3: pt[e] = w[6] ? (pt[e] == st[e] ? en[e] : pt[e] - 7'h01) : (pt[e] == en[e] ? st[e] : pt[e] + 7'h01);
                3'h6, 3'h7: pt[e] = a;
                default: ;
            endcase
            if (w[9:7] == 3'h0 || w[9:7] == 3'h7 || (w[9:7] == 3'h3 && !w[0])) begin
                rw[e] = i_row_store.mem[pt[e]][9:0];
            end
        end
    endtask
    task do_instr(input [1:0] e, input [15:0] w);
        k = 0;
        while (instr_ready !== 1'b1 && k < 40) begin
            @(negedge mclk);
            k = k + 1;
        end
        if (k == 40) errors = errors + 1;
        instr_valid = 1'b1;
        instr_engine = e;
        instr_word = w;
        model_op(e, w);
        @(negedge mclk);
        instr_valid = 1'b0;
        repeat (3) @(negedge mclk);
    endtask
    task pwm_step;
        integer n, e, hit;
        r = lfsr(r);
        eng_pwm_1 = r[11:0];
        r = lfsr(r);
        eng_pwm_2 = r[11:0];
        r = lfsr(r);
        eng_pwm_3 = r[11:0];
        r = lfsr(r);
        {host_pwm_wdata, host_pwm_sel, host_pwm_wr, eng_pwm_upd} = r;
        map_read_addr = 8'h6E + r[11:8];
        for (n = 0; n < 9; n = n + 1) begin
            hit = 0;
            for (e = 0; e < 3; e = e + 1) begin
                if (!hit && rw[e][n]) begin
                    hit = 1;
                    if (eng_pwm_upd[e]) lvl[n*12 +: 12] = e == 0 ? eng_pwm_1 : (e == 1 ? eng_pwm_2 : eng_pwm_3);
                end
            end
            if (!hit && host_pwm_wr && host_pwm_sel == n) lvl[n*12 +: 12] = {host_pwm_wdata, 4'h0};
        end
        @(negedge mclk);
        eng_pwm_upd = 3'h0;
        host_pwm_wr = 1'b0;
        chk_map(map_read_data, rb(map_read_addr));
        chk_map(row_ptr, {pt[2], pt[1], pt[0]});
        chk_map(engine_owned, rw[0][8:0] | rw[1][8:0] | rw[2][8:0]);
        chk_map(fader_en, {rw[2][9], rw[1][9], rw[0][9]});
        chk_pwm(driver_output_n, lvl);
        chk_pwm(pwm_reg, hi8(lvl));
    endtask
    ////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // Engine ticks must come exactly one divider period apart.
    always @(negedge mclk) begin
        gap = gap + 1;
        if (rst_b === 1'b1 && engine_tick === 1'b1) begin
            if (seen) chk_map(gap[20:0], TICK_DIV);
            seen = 1;
            gap = 0;
        end
    end
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            errors = errors + 1;
            test_done;
        end
    end
    initial begin
        {rst_b, instr_valid, instr_engine, instr_word, eng_pwm_upd, host_pwm_wr} = 0;
        {eng_pwm_1, eng_pwm_2, eng_pwm_3, host_pwm_sel, host_pwm_wdata, map_read_addr} = 0;
        r = 16'h003B;
        lvl = 108'h0;
        for (i = 0; i < 3; i = i + 1) begin
            {st[i], en[i], pt[i], rw[i]} = 0;
        end
        for (i = 0; i < 128; i = i + 1) begin
            r = lfsr(r);
            i_row_store.mem[i] = r;
        end
        repeat (12) @(negedge mclk);
        rst_b = 1'b1;
        for (i = 0; i < 13; i = i + 1) begin
            do_instr(2'h0, {9'h13A, i[6:0]});
            pwm_step;
        end
        for (i = 0; i < 8; i = i + 1) begin
            do_instr(2'h1, i < 2 ? (i == 0 ? 16'h9E02 : 16'h9C83) : (i < 5 ? 16'h9D80 : 16'h9DC0));
            pwm_step;
        end
        for (i = 0; i < 300; i = i + 1) begin
            r = lfsr(r);
            do_instr(r[1:0], r[15:14] == 2'h0 ? r : {6'h27, r[9:7], r[13] ? r[6:0] : {4'h0, r[2:0]}});
            pwm_step;
        end
        test_done;
    end
endmodule
